/* File: tsa_temp_alert.sv */
// How it works
// - Readings are 8-bit twos complement, rounded half up, clamped to +127 and -65.
// - Per-channel high and low limits; reaching either limit sets the alert latch.
// - High limits reset to 7Fh, low limits reset to C9h.
// - Open detector is sampled at each conversion start into the open flag.
// - After reset the open flag reads clear until a conversion starts.
// - Remote short to return or ground gives a remote reading of zero.
// - Remote short to supply gives +127 on both channels and raises alarms.
// - Alert is latched; only a successful alert response read clears it.
// - Limit comparisons and a disconnected diode both set the alert latch.
// - Conversions and reading updates continue while alert is asserted.
// - Alert pin is open drain: pulled low or released only.
// - Alert events arise only at a conversion start with the diode open, or when a conversion produces a result.
// - Alert response returns the strapped 7-bit address with bit 0 set.
// - Address is sent with arbitration; lower address wins.
// - Losing responder keeps its latch and line low; host input is level.
// - Read codes 00h to 08h select readings, status, config, rate, limits.
// - Write codes 09h to 0Eh select config, rate and the four limits.
// - Code 0Fh, sent without data, starts a single conversion.
// - Readings and config reset to zero, conversion rate to 02h.
// - Register pointer resets to zero so a bare read returns local temp.
// - Status flags stay set until reset or a status read.
// - Config bit 7 set suppresses all alert assertions.
`timescale 1ns/1ps

module tsa_temp_alert (
    // System clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Link sampling clock
    input wire logic lclk_i,
    // Serial bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Alert pin
    output logic alert_o,
    output logic alert_oe_o,
    // Address straps, bit 6 is resp_addr_bit_top, bit 0 is resp_addr_bit_low
    input wire logic [6:0] resp_addr_i,
    // Converter results
    input wire logic conv_start_i,
    input wire logic conv_busy_i,
    input wire logic diode_open_i,
    input wire logic conv_valid_i,
    input wire logic conv_chan_i,
    input wire logic signed [10:0] conv_temp_i,
    input wire logic short_gnd_i,
    input wire logic short_vcc_i,
    // Converter control
    output logic oneshot_o,
    output logic run_stop_o,
    output logic [2:0] conv_rate_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain state
    tsa_pkg::tsa_link_state_type st_r, st_nxt;
    tsa_pkg::tsa_req_type req_r, req_nxt;
    tsa_pkg::tsa_ans_type ans_r;
    logic [2:0] scl_sy_r, sda_sy_r, ack_sy_r;
    logic scl_f_r, sda_f_r, scl_q_r, sda_q_r, ack_seen_r;
    logic [7:0] sh_r, sh_nxt, cmd_r, cmd_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic sda_oe_r, sdaoe_nxt, scl_oe_r, scloe_nxt, ara_r, ara_nxt;
    logic wbyte_r, wbyte_nxt, gotx_r, gotx_nxt, req_tgl_r, tgl_nxt;
    logic [6:0] own_r;
    logic own_ok_r, pin_zero_r;
    // Answer toggle from the core domain, declared here because the link filter reads it
    logic ack_tgl_r, ack_take;

    // Three-stage pin filters, a change counts once stages two and three agree
    always_ff @(posedge lclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_sy_r <= 3'h7;
            sda_sy_r <= 3'h7;
            ack_sy_r <= 3'h0;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            ack_seen_r <= 1'b0;
        end else begin
            scl_sy_r <= {scl_sy_r[1:0], scl_i};
            sda_sy_r <= {sda_sy_r[1:0], sda_i};
            ack_sy_r <= {ack_sy_r[1:0], ack_tgl_r};
            scl_f_r <= (scl_sy_r[1] == scl_sy_r[2]) ? scl_sy_r[2] : scl_f_r;
            sda_f_r <= (sda_sy_r[1] == sda_sy_r[2]) ? sda_sy_r[2] : sda_f_r;
            scl_q_r <= scl_f_r;
            sda_q_r <= sda_f_r;
            ack_seen_r <= ack_take ? ack_sy_r[2] : ack_seen_r;
        end
    end

    // Bus events from the filtered levels
    wire scl_rise = scl_f_r & ~scl_q_r;
    wire scl_fall = ~scl_f_r & scl_q_r;
    wire start_det = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
    wire stop_det = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;
    wire byte_done = scl_fall & (cnt_r == tsa_pkg::BITS_BYTE);
    assign ack_take = (ack_sy_r[1] == ack_sy_r[2]) & (ack_sy_r[2] != ack_seen_r);
    wire a_own = (sh_r[7:1] == own_r);
    wire a_ara = (sh_r[7:1] == tsa_pkg::ARA_ADDR) & sh_r[0];
    wire [7:0] ara_byte = {own_r, 1'b1};
    wire arb_lost = scl_rise & ~sda_oe_r & ~sda_f_r;

    // Byte framing, acknowledge, clock stretch while the core answers
    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        sdaoe_nxt = sda_oe_r;
        scloe_nxt = scl_oe_r;
        ara_nxt = ara_r;
        wbyte_nxt = wbyte_r;
        gotx_nxt = gotx_r;
        cmd_nxt = cmd_r;
        req_nxt = req_r;
        tgl_nxt = req_tgl_r;
        case (st_r)
            tsa_pkg::LS_IDLE: begin
                st_nxt = tsa_pkg::LS_IDLE;
            end
            tsa_pkg::LS_ADDR, tsa_pkg::LS_RX: begin
                if (scl_rise) begin
                    sh_nxt = {sh_r[6:0], sda_f_r};
                    cnt_nxt = cnt_r + 4'h1;
                end
                if (byte_done && st_r == tsa_pkg::LS_RX) begin
                    req_nxt.op = wbyte_r ? tsa_pkg::OP_WR : tsa_pkg::OP_CMD;
                    req_nxt.cmd = wbyte_r ? cmd_r : sh_r;
                    req_nxt.data = sh_r;
                    cmd_nxt = wbyte_r ? cmd_r : sh_r;
                    tgl_nxt = ~req_tgl_r;
                    wbyte_nxt = 1'b1;
                    sdaoe_nxt = 1'b1;
                    gotx_nxt = 1'b0;
                    st_nxt = tsa_pkg::LS_ACK;
                end else if (byte_done && a_own && !sh_r[0]) begin
                    sdaoe_nxt = 1'b1;
                    gotx_nxt = 1'b0;
                    wbyte_nxt = 1'b0;
                    st_nxt = tsa_pkg::LS_ACK;
                end else if (byte_done && (a_own || a_ara)) begin
                    scloe_nxt = 1'b1;
                    ara_nxt = a_ara;
                    req_nxt.op = a_ara ? tsa_pkg::OP_ARA : tsa_pkg::OP_RD;
                    tgl_nxt = ~req_tgl_r;
                    st_nxt = tsa_pkg::LS_WAIT;
                end else if (byte_done) begin
                    st_nxt = tsa_pkg::LS_IDLE;
                end
            end
            tsa_pkg::LS_WAIT: begin
                // Only responders with a pending alert take part
                if (ack_take && ara_r && !ans_r.pend) begin
                    scloe_nxt = 1'b0;
                    st_nxt = tsa_pkg::LS_IDLE;
                end else if (ack_take) begin
                    sh_nxt = ara_r ? ara_byte : ans_r.data;
                    sdaoe_nxt = 1'b1;
                    gotx_nxt = 1'b1;
                    st_nxt = tsa_pkg::LS_ACK;
                end
            end
            tsa_pkg::LS_ACK: begin
                // Clock released one cycle after data settles, never together
                if (scl_oe_r) begin
                    scloe_nxt = 1'b0;
                end
                if (scl_fall) begin
                    cnt_nxt = 4'h0;
                    sdaoe_nxt = gotx_r ? ~sh_r[7] : 1'b0;
                    st_nxt = gotx_r ? tsa_pkg::LS_TX : tsa_pkg::LS_RX;
                end
            end
            tsa_pkg::LS_TX: begin
                if (scl_rise) begin
                    cnt_nxt = cnt_r + 4'h1;
                end
                if (arb_lost) begin
                    st_nxt = tsa_pkg::LS_IDLE;
                end else if (byte_done) begin
                    sdaoe_nxt = 1'b0;
                    st_nxt = tsa_pkg::LS_IDLE;
                    if (ara_r) begin
                        req_nxt.op = tsa_pkg::OP_ARA_OK;
                        tgl_nxt = ~req_tgl_r;
                    end
                end else if (scl_fall) begin
                    sh_nxt = {sh_r[6:0], 1'b0};
                    sdaoe_nxt = ~sh_r[6];
                end
            end
            default: begin
                st_nxt = tsa_pkg::LS_IDLE;
            end
        endcase
        if (start_det) begin
            st_nxt = tsa_pkg::LS_ADDR;
            cnt_nxt = 4'h0;
            sdaoe_nxt = 1'b0;
            scloe_nxt = 1'b0;
        end else if (stop_det) begin
            st_nxt = tsa_pkg::LS_IDLE;
            sdaoe_nxt = 1'b0;
            scloe_nxt = 1'b0;
        end
    end

    // Link registers; straps caught on the first edge after release
    always_ff @(posedge lclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= tsa_pkg::LS_IDLE;
            sh_r <= 8'h00;
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            ara_r <= 1'b0;
            wbyte_r <= 1'b0;
            gotx_r <= 1'b0;
            cmd_r <= 8'h00;
            req_r <= '0;
            req_tgl_r <= 1'b0;
            own_r <= 7'h00;
            own_ok_r <= 1'b0;
            pin_zero_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            sda_oe_r <= sdaoe_nxt;
            scl_oe_r <= scloe_nxt;
            ara_r <= ara_nxt;
            wbyte_r <= wbyte_nxt;
            gotx_r <= gotx_nxt;
            cmd_r <= cmd_nxt;
            req_r <= req_nxt;
            req_tgl_r <= tgl_nxt;
            own_r <= own_ok_r ? own_r : resp_addr_i;
            own_ok_r <= 1'b1;
            pin_zero_r <= 1'b0;
        end
    end

    // Open-drain pins drive only low
    assign scl_o = pin_zero_r;
    assign scl_oe_o = scl_oe_r;
    assign sda_o = pin_zero_r;
    assign sda_oe_o = sda_oe_r;

    a_ara_lose: assert property (@(posedge lclk_i) disable iff (!nrst_i)
        (st_r == tsa_pkg::LS_TX) && arb_lost && !start_det |=> (st_r == tsa_pkg::LS_IDLE) && !sda_oe_r && !req_tgl_r == $past(!req_tgl_r))
        else $error("arbitration loss not handled");

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain
    logic [2:0] req_sy_r;
    logic req_seen_r, alert_r, oneshot_r, alert_zero_r;
    logic [7:0] loc_r, rem_r, cfg_r, rate_r, lhi_r, llo_r, rhi_r, rlo_r, ptr_r;
    logic [4:0] flags_r;

    // Request handshake, toggle filtered like a pin
    wire take = (req_sy_r[1] == req_sy_r[2]) & (req_sy_r[2] != req_seen_r);
    wire op_cmd = take & (req_r.op == tsa_pkg::OP_CMD);
    wire op_wr = take & (req_r.op == tsa_pkg::OP_WR);
    wire op_rd = take & (req_r.op == tsa_pkg::OP_RD);
    wire op_ara = take & (req_r.op == tsa_pkg::OP_ARA);
    wire op_ara_ok = take & (req_r.op == tsa_pkg::OP_ARA_OK);
    wire ptr_set = op_cmd | op_wr;
    wire oneshot_set = ptr_set & (req_r.cmd == tsa_pkg::CMD_ONESHOT);

    // Rounding and clamping of the quarter-degree raw value
    wire signed [11:0] rnd_sum = $signed({conv_temp_i[10], conv_temp_i}) + tsa_pkg::ROUND_HALF;
    wire signed [9:0] rnd_deg = rnd_sum[11:2];
    wire [7:0] clamped = (rnd_deg > tsa_pkg::DEG_MAX) ? tsa_pkg::DEG_MAX[7:0] :
        (rnd_deg < tsa_pkg::DEG_MIN) ? tsa_pkg::DEG_MIN[7:0] : rnd_deg[7:0];
    wire [7:0] temp_new = short_vcc_i ? tsa_pkg::TEMP_MAX :
        (conv_chan_i && short_gnd_i) ? tsa_pkg::TEMP_SHORT : clamped;

    // Limit checks on the fresh result, same cycle as the reading update
    wire [7:0] hi_sel = conv_chan_i ? rhi_r : lhi_r;
    wire [7:0] lo_sel = conv_chan_i ? rlo_r : llo_r;
    wire ge_hi = $signed(temp_new) >= $signed(hi_sel);
    wire le_lo = $signed(temp_new) <= $signed(lo_sel);
    wire [4:0] flag_set = {conv_valid_i & ~conv_chan_i & ge_hi, conv_valid_i & ~conv_chan_i & le_lo,
        conv_valid_i & conv_chan_i & ge_hi, conv_valid_i & conv_chan_i & le_lo,
        conv_start_i & diode_open_i};
    wire stat_clr = op_rd & (ptr_r == tsa_pkg::CMD_STATUS);
    // Set wins over a status read in the same cycle
    wire [4:0] flags_nxt = flag_set | (flags_r & ~{5{stat_clr}});
    wire alert_set = (|flag_set) & ~cfg_r[tsa_pkg::CFG_MASK_BIT];
    wire alert_nxt = alert_set | (alert_r & ~op_ara_ok);

    // Read selection by pointer
    logic [7:0] rd_tab [0:8];
    assign rd_tab[0] = loc_r;
    assign rd_tab[1] = rem_r;
    assign rd_tab[2] = {conv_busy_i, flags_r, 2'b00};
    assign rd_tab[3] = cfg_r & tsa_pkg::CFG_RD_MASK;
    assign rd_tab[4] = rate_r;
    assign rd_tab[5] = lhi_r;
    assign rd_tab[6] = llo_r;
    assign rd_tab[7] = rhi_r;
    assign rd_tab[8] = rlo_r;
    wire [7:0] rd_byte = (ptr_r <= tsa_pkg::CMD_RD_REM_LOW) ? rd_tab[ptr_r[3:0]] : tsa_pkg::RD_UNMAPPED;

    // Write strobes
    wire w_cfg = op_wr & (req_r.cmd == tsa_pkg::CMD_WR_CONFIG);
    wire w_rate = op_wr & (req_r.cmd == tsa_pkg::CMD_WR_RATE);
    wire w_lhi = op_wr & (req_r.cmd == tsa_pkg::CMD_WR_LOC_HIGH);
    wire w_llo = op_wr & (req_r.cmd == tsa_pkg::CMD_WR_LOC_LOW);
    wire w_rhi = op_wr & (req_r.cmd == tsa_pkg::CMD_WR_REM_HIGH);
    wire w_rlo = op_wr & (req_r.cmd == tsa_pkg::CMD_WR_REM_LOW);

    // Request sync and answer; answer word loads on the same edge that moves the toggle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_sy_r <= 3'h0;
            req_seen_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            ans_r <= '0;
        end else begin
            req_sy_r <= {req_sy_r[1:0], req_tgl_r};
            req_seen_r <= take ? req_sy_r[2] : req_seen_r;
            ack_tgl_r <= take ? ~ack_tgl_r : ack_tgl_r;
            ans_r.data <= op_rd ? rd_byte : ans_r.data;
            ans_r.pend <= op_ara ? alert_r : ans_r.pend;
        end
    end

    // Registers, readings keep updating whatever the alert does
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loc_r <= tsa_pkg::RST_TEMP;
            rem_r <= tsa_pkg::RST_TEMP;
            cfg_r <= tsa_pkg::RST_CONFIG;
            rate_r <= tsa_pkg::RST_RATE;
            lhi_r <= tsa_pkg::RST_HIGH_LIMIT;
            rhi_r <= tsa_pkg::RST_HIGH_LIMIT;
            llo_r <= tsa_pkg::RST_LOW_LIMIT;
            rlo_r <= tsa_pkg::RST_LOW_LIMIT;
            ptr_r <= tsa_pkg::RST_PTR;
            flags_r <= 5'h00;
            alert_r <= 1'b0;
            oneshot_r <= 1'b0;
            alert_zero_r <= 1'b0;
        end else begin
            loc_r <= (conv_valid_i && !conv_chan_i) ? temp_new : loc_r;
            rem_r <= (conv_valid_i && conv_chan_i) ? temp_new : rem_r;
            cfg_r <= w_cfg ? req_r.data : cfg_r;
            rate_r <= w_rate ? req_r.data : rate_r;
            lhi_r <= w_lhi ? req_r.data : lhi_r;
            llo_r <= w_llo ? req_r.data : llo_r;
            rhi_r <= w_rhi ? req_r.data : rhi_r;
            rlo_r <= w_rlo ? req_r.data : rlo_r;
            ptr_r <= ptr_set ? req_r.cmd : ptr_r;
            flags_r <= flags_nxt;
            alert_r <= alert_nxt;
            oneshot_r <= oneshot_set;
            alert_zero_r <= 1'b0;
        end
    end

    // Converter control and alert pin
    assign oneshot_o = oneshot_r;
    assign run_stop_o = cfg_r[tsa_pkg::CFG_RUN_BIT];
    assign conv_rate_o = rate_r[2:0];
    assign alert_o = alert_zero_r;
    assign alert_oe_o = alert_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_loc_clean;
        conv_valid_i && !conv_chan_i && !short_vcc_i;
    endsequence

    a_reset_defaults: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> lhi_r == 8'h7F && rhi_r == 8'h7F && llo_r == 8'hC9 && rlo_r == 8'hC9
            && loc_r == 8'h00 && rem_r == 8'h00 && rate_r == 8'h02 && ptr_r == 8'h00 && flags_r == 5'h00)
        else $error("reset defaults wrong");
    a_clamp_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_loc_clean ##0 (conv_temp_i >= 11'sd506) |=> loc_r == 8'h7F)
        else $error("high clamp wrong");
    a_clamp_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_loc_clean ##0 (conv_temp_i < -11'sd262) |=> loc_r == 8'hBF)
        else $error("low clamp wrong");
    a_short_ground: assert property (@(posedge clk_i) disable iff (!nrst_i)
        conv_valid_i && conv_chan_i && short_gnd_i && !short_vcc_i |=> rem_r == 8'h00)
        else $error("ground short reading wrong");
    a_short_supply: assert property (@(posedge clk_i) disable iff (!nrst_i)
        conv_valid_i && short_vcc_i && !cfg_r[7] |=> (conv_chan_i ? rem_r : loc_r) == 8'h7F && alert_r)
        else $error("supply short not reported");
    a_alarm_trip: assert property (@(posedge clk_i) disable iff (!nrst_i)
        conv_valid_i && !conv_chan_i && $signed(temp_new) >= $signed(lhi_r) |=> flags_r[4] ##0 (alert_r || $past(cfg_r[7])))
        else $error("local high alarm missed");
    a_mask_blocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !alert_r && cfg_r[7] |=> !alert_r)
        else $error("masked alert asserted");
    a_latch_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        alert_r && !op_ara_ok |=> alert_r [*1])
        else $error("alert latch cleared without response read");
    a_open_sample: assert property (@(posedge clk_i) disable iff (!nrst_i)
        conv_start_i && diode_open_i |=> flags_r[0] && rd_tab[2][2])
        else $error("open fault not sampled");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
        flags_r[3] && !stat_clr |=> flags_r[3])
        else $error("status flag dropped");

endmodule // tsa_temp_alert

/* File: tsa_pkg.sv */
package tsa_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_LOC_TEMP = 8'h00;
    localparam logic [7:0] CMD_REM_TEMP = 8'h01;
    localparam logic [7:0] CMD_STATUS = 8'h02;
    localparam logic [7:0] CMD_RD_CONFIG = 8'h03;
    localparam logic [7:0] CMD_RD_RATE = 8'h04;
    localparam logic [7:0] CMD_RD_LOC_HIGH = 8'h05;
    localparam logic [7:0] CMD_RD_LOC_LOW = 8'h06;
    localparam logic [7:0] CMD_RD_REM_HIGH = 8'h07;
    localparam logic [7:0] CMD_RD_REM_LOW = 8'h08;
    localparam logic [7:0] CMD_WR_CONFIG = 8'h09;
    localparam logic [7:0] CMD_WR_RATE = 8'h0A;
    localparam logic [7:0] CMD_WR_LOC_HIGH = 8'h0B;
    localparam logic [7:0] CMD_WR_LOC_LOW = 8'h0C;
    localparam logic [7:0] CMD_WR_REM_HIGH = 8'h0D;
    localparam logic [7:0] CMD_WR_REM_LOW = 8'h0E;
    localparam logic [7:0] CMD_ONESHOT = 8'h0F;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_HIGH_LIMIT = 8'h7F;
    localparam logic [7:0] RST_LOW_LIMIT = 8'hC9;
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h02;
    localparam logic [7:0] RST_PTR = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Temperature format, raw input is signed quarter degrees
    localparam logic [7:0] TEMP_MAX = 8'h7F;
    localparam logic [7:0] TEMP_SHORT = 8'h00;
    localparam logic signed [9:0] DEG_MAX = 10'sh07F;
    localparam logic signed [9:0] DEG_MIN = 10'sh3BF;
    localparam logic signed [11:0] ROUND_HALF = 12'sh002;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_RUN_BIT = 6;
    localparam logic [7:0] CFG_RD_MASK = 8'hC0;
    localparam int FLG_LHIGH = 4;
    localparam int FLG_LLOW = 3;
    localparam int FLG_RHIGH = 2;
    localparam int FLG_RLOW = 1;
    localparam int FLG_OPEN = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Link framing
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [2:0] OP_CMD = 3'h0;
    localparam logic [2:0] OP_WR = 3'h1;
    localparam logic [2:0] OP_RD = 3'h2;
    localparam logic [2:0] OP_ARA = 3'h3;
    localparam logic [2:0] OP_ARA_OK = 3'h4;

    typedef struct packed {logic [2:0] op; logic [7:0] cmd; logic [7:0] data;} tsa_req_type;
    typedef struct packed {logic pend; logic [7:0] data;} tsa_ans_type;
    typedef enum logic [5:0] {
        LS_IDLE = 6'h01, LS_ADDR = 6'h02, LS_ACK = 6'h04,
        LS_RX = 6'h08, LS_WAIT = 6'h10, LS_TX = 6'h20
    } tsa_link_state_type;

endpackage

/* File: tsa_host.sv */
`timescale 1ns/1ps
module tsa_host #(parameter logic [6:0] SADDR = 7'h18) (
    // Wire levels
    input wire logic scl_i,
    input wire logic sda_i,
    // Pull-downs, high pulls low
    output logic scl_dn_o,
    output logic sda_dn_o
);
    // Slow bit phase so the link filter settles
    localparam int T = 250;
    logic [7:0] q;
    logic a;
    initial begin
        scl_dn_o = 1'b0;
        sda_dn_o = 1'b0;
    end
    // Data moves only while SCL low; stretching is waited out
    task automatic bx(input logic b, output logic r);
        sda_dn_o = ~b;
        #T scl_dn_o = 1'b0;
        wait (scl_i === 1'b1);
        #T r = sda_i;
        scl_dn_o = 1'b1;
    endtask
    task automatic st();
        sda_dn_o = 1'b0;
        #T scl_dn_o = 1'b0;
        #T sda_dn_o = 1'b1;
        #T scl_dn_o = 1'b1;
    endtask
    task automatic sp();
        sda_dn_o = 1'b1;
        #T scl_dn_o = 1'b0;
        #T sda_dn_o = 1'b0;
        #T;
    endtask
    // Eight bits then the ack slot, host never acks read data
    task automatic by(input logic [7:0] w, output logic [7:0] r, output logic nak);
        for (int i = 7; i >= 0; i--) bx(w[i], r[i]);
        bx(1'b1, nak);
    endtask
    // Write Byte when two is set, else Send Byte
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic two, output logic nak);
        logic n1;
        logic n2;
        st();
        by({SADDR, 1'b0}, q, nak);
        by(c, q, n1);
        n2 = 1'b0;
        if (two) by(d, q, n2);
        sp();
        nak = nak | n1 | n2;
    endtask
    // Receive Byte, own address or alert response address
    task automatic rcv(input logic [6:0] ad, output logic [7:0] d, output logic nak);
        st();
        by({ad, 1'b1}, q, nak);
        by(8'hFF, d, a);
        sp();
    endtask
endmodule // tsa_host

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] SADDR = 7'h18;
    logic clk_i, lclk_i, nrst_i, conv_start_i, conv_valid_i, conv_chan_i, nak;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, alert_o, alert_oe_o, oneshot_o, run_stop_o, scl_dn, sda_dn;
    logic signed [10:0] conv_temp_i;
    logic [2:0] conv_rate_o;
    logic sg, sv, dop;
    logic [7:0] rd;
    logic [7:0] wv [0:5];
    logic [31:0] lf = 32'h9C35;
    logic [7:0] m [0:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
    int rv [0:3] = '{2, 1, -2, -3};
    int miscompares = 0, checked = 0, oneshots = 0;
    // Pulled-up wires
    wire logic scl_w = ~(scl_dn | scl_oe_o);
    wire logic sda_w = ~(sda_dn | sda_oe_o);
    tsa_temp_alert u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .lclk_i(lclk_i), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_o(alert_o),
        .alert_oe_o(alert_oe_o), .resp_addr_i(SADDR), .conv_start_i(conv_start_i), .conv_busy_i(1'b0),
        .diode_open_i(dop), .conv_valid_i(conv_valid_i), .conv_chan_i(conv_chan_i), .conv_temp_i(conv_temp_i),
        .short_gnd_i(sg), .short_vcc_i(sv), .oneshot_o(oneshot_o), .run_stop_o(run_stop_o),
        .conv_rate_o(conv_rate_o));
    tsa_host #(.SADDR(SADDR)) host (.scl_i(scl_w), .sda_i(sda_w), .scl_dn_o(scl_dn), .sda_dn_o(sda_dn));
    // Two clocks, phases unrelated
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        lclk_i = 1'b0;
        #1.7;
        forever #3 lclk_i = ~lclk_i;
    end
    always @(posedge clk_i) if (oneshot_o === 1'b1) oneshots++;
    ////////////////////////////////////////////////////////////////////////////////
    // Half-up rounding of quarter degrees, then clamping
    function automatic logic [7:0] rnd(input int raw);
        int t;
        t = (raw + 2) >>> 2;
        if (t > 127) t = 127;
        if (t < -65) t = -65;
        return t[7:0];
    endfunction
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rr(input logic [7:0] c);
        host.wr(c, 8'h00, 1'b0, nak);
        host.rcv(SADDR, rd, nak);
        chk("register", m[c], rd);
    endtask
    task automatic conv(input logic ch, input int raw);
        @(negedge clk_i);
        conv_start_i = 1'b1;
        @(negedge clk_i);
        {conv_start_i, conv_chan_i, conv_temp_i, conv_valid_i} = {1'b0, ch, raw[10:0], 1'b1};
        @(negedge clk_i);
        conv_valid_i = 1'b0;
        m[ch] = rnd(raw);
        repeat (3) @(negedge clk_i);
    endtask
    task automatic final_report();
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard, runs well past the expected length
    initial begin
        #3000000;
        miscompares++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst_i, conv_start_i, conv_valid_i, conv_chan_i, conv_temp_i} = 15'h0000;
        {sg, sv, dop} = 3'b000;
        repeat (8) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        host.rcv(SADDR, rd, nak);
        chk("first read", m[0], rd);
        host.rcv(tsa_pkg::ARA_ADDR, rd, nak);
        chk("idle alert ack", 8'h01, 8'(nak));
        for (int c = 3; c < 9; c++) rr(8'(c));
        lf = nx(lf);
        wv = '{lf[7:0] & 8'h7F, lf[15:8], 8'h19, 8'hE7, 8'h7F, 8'hC9};
        for (int i = 0; i < 6; i++) host.wr(8'(9 + i), wv[i], 1'b1, nak);
        m[3] = wv[0] & tsa_pkg::CFG_RD_MASK;
        for (int i = 1; i < 6; i++) m[3 + i] = wv[i];
        for (int c = 3; c < 9; c++) rr(8'(c));
        chk("rate pins", 8'(lf[10:8]), 8'(conv_rate_o));
        for (int i = 0; i < 8; i++) begin
            lf = nx(lf);
            conv(1'b0, i < 4 ? rv[i] : int'(lf % 193) - 96);
            rr(8'h00);
        end
        chk("alert quiet", 8'h00, 8'(alert_oe_o));
        conv(1'b0, 100);
        chk("alert at limit", 8'h01, 8'(alert_oe_o));
        conv(1'b1, 520);
        conv(1'b0, -280);
        rr(8'h00);
        rr(8'h01);
        host.rcv(tsa_pkg::ARA_ADDR, rd, nak);
        chk("alert answer", {SADDR, 1'b1}, rd);
        repeat (20) @(negedge clk_i);
        chk("alert cleared", 8'h00, 8'(alert_oe_o));
        // Faults: open diode at start, ground short remote, supply short local
        {sg, dop} = 2'b11;
        conv(1'b1, 40);
        sv = 1'b1;
        conv(1'b0, 0);
        {sg, sv, dop} = 3'b000;
        m[0] = 8'h7F;
        m[1] = 8'h00;
        m[2] = 8'h74;
        for (int c = 0; c < 3; c++) rr(8'(c));
        host.rcv(tsa_pkg::ARA_ADDR, rd, nak);
        chk("alert again", {SADDR, 1'b1}, rd);
        repeat (20) @(negedge clk_i);
        host.wr(8'h09, 8'h80, 1'b1, nak);
        conv(1'b0, 100);
        chk("alert masked", 8'h00, 8'(alert_oe_o));
        host.wr(8'h0F, 8'h00, 1'b0, nak);
        chk("one shot", 8'h01, 8'(oneshots));
        final_report();
    end
endmodule // tb_top
